// File: src/lpsc_regs.vh
`ifndef LPSC_REGS_VH
`define LPSC_REGS_VH
// Cycles from acknowledge response phase to stop-grant entry
`define LPSC_GRANT_DELAY     8'h14
// Cycles each voltage-ID step is held before the next one
`define LPSC_VID_STEP_CYC    8'h04
// Cycles allowed for a core-ratio change to settle
`define LPSC_RATIO_SETTLE    8'h04
// Voltage-ID code reset value and low-power code default
`define LPSC_VID_RESET       6'h20
`define LPSC_VID_LOW         6'h10
// Core ratio reset value and low-power ratio default
`define LPSC_RATIO_RESET     5'h0c
`define LPSC_RATIO_LOW       5'h06
// Highest ratio the part may run at
`define LPSC_RATIO_TOP       5'h0c
`endif

// File: src/lpsc_event_latch.v
`timescale 1ns/1ps
`default_nettype none
// Holds one pending occurrence of each break event while servicing is held
module lpsc_event_latch #(
  parameter WIDTH = 4
) (
  // Clock and reset
  input  wire             ref_clk,
  input  wire             rst,
  // Events and control
  input  wire [WIDTH-1:0] eventIn,
  input  wire             holdOff,
  input  wire             releaseAll,
  // Pending events
  output reg  [WIDTH-1:0] pendingOut
);
  // Set wins over release so an event in the release cycle is kept
  always @(posedge ref_clk) begin
    if (rst) begin
      pendingOut <= {WIDTH{1'b0}};
    end else begin
      pendingOut <= ((releaseAll ? {WIDTH{1'b0}} : pendingOut)
                    | (holdOff ? eventIn : {WIDTH{1'b0}}));
    end
  end
endmodule
`default_nettype wire

// File: src/lpsc_vid_stepper.v
`timescale 1ns/1ps
`default_nettype none
`include "lpsc_regs.vh"
// Walks the voltage-ID code one step per interval toward its target
module lpsc_vid_stepper #(
  parameter [7:0] STEP_CYC = `LPSC_VID_STEP_CYC
) (
  // Clock and reset
  input  wire       ref_clk,
  input  wire       rst,
  // Target
  input  wire [5:0] targetCode,
  // Output code and status
  output reg  [5:0] vidCode,
  output wire       vidSettled
);
  reg [7:0] waitReg;
  assign vidSettled = (vidCode == targetCode) && (waitReg == 8'h00);
  // One 12.5 mV code step at a time limits supply slew
  always @(posedge ref_clk) begin
    if (rst) begin
      vidCode <= `LPSC_VID_RESET;
      waitReg <= 8'h00;
    end else if (waitReg != 8'h00) begin
      waitReg <= waitReg - 8'h01;
    end else if (vidCode < targetCode) begin
      vidCode <= vidCode + 6'h01;
      waitReg <= STEP_CYC;
    end else if (vidCode > targetCode) begin
      vidCode <= vidCode - 6'h01;
      waitReg <= STEP_CYC;
    end
  end
endmodule
`default_nettype wire

// File: src/lpsc_controller.v
`timescale 1ns/1ps
`default_nettype none
`include "lpsc_regs.vh"
// Contract
// - Halt only when every core halted
// - Halt exits on mgmt, init, local irq
// - Init while halted starts initialization
// - Handler return resumes normal or halt
// - Stop-clock in halt returns to halt
// - Snoops serviced while halted
// - Enable picks enhanced halt over halt
// - Enhanced entry: ratio down, then voltage
// - Only core clock changes, bus unchanged
// - Enhanced halt exit: voltage up, ratio
// - Same exit order for enhanced grant
// - Grant 20 clocks after acknowledge response
// - Init in grant stays until release
// - Stop-clock release returns to normal
// - Latch events in grant, service once
// - Enable picks enhanced stop-grant
// - Snoop state until serviced, then return
// - Enhanced snoop keeps low operating point
// - Package voltage is highest core request
// - Raise voltage stepwise before faster ratio
// - Slower ratio first, then lower voltage
module lpsc_controller #(
  parameter [7:0] GRANT_DELAY = `LPSC_GRANT_DELAY,
  parameter [7:0] STEP_CYC    = `LPSC_VID_STEP_CYC,
  parameter [7:0] SETTLE_CYC  = `LPSC_RATIO_SETTLE
) (
  // Clock and reset
  input  wire       ref_clk,
  input  wire       rst,
  // Core status
  input  wire [1:0] coreHalted,
  input  wire       handlerDone,
  input  wire       resumeHalt,
  // Chipset requests, from pins
  input  wire       stop_clock_request_n,
  input  wire       system_mgmt_irq_n,
  input  wire       init_request_n,
  input  wire [1:0] local_irq_pins,
  // Bus cycle status
  input  wire       ackResponse,
  input  wire       snoopSeen,
  input  wire       snoopServiced,
  // Configuration
  input  wire       enhHaltEnable,
  input  wire       enhGrantEnable,
  input  wire [4:0] lowRatio,
  input  wire [5:0] lowVid,
  // Software performance targets per core
  input  wire [4:0] perfRatio0,
  input  wire [4:0] perfRatio1,
  input  wire [5:0] perfVid0,
  input  wire [5:0] perfVid1,
  // Outputs
  output wire [8:0] powerState,
  output reg        ackCycleReq,
  output reg        initStart,
  output reg  [3:0] serviceEvents,
  output reg  [4:0] coreRatio,
  output wire [5:0] voltage_id_code,
  output wire       coreClockStopped
);
  // One-hot states
  localparam [8:0] S_NORMAL = 9'h001;
  localparam [8:0] S_HALT   = 9'h002;
  localparam [8:0] S_EHALT  = 9'h004;
  localparam [8:0] S_HSNP   = 9'h008;
  localparam [8:0] S_EHSNP  = 9'h010;
  localparam [8:0] S_GWAIT  = 9'h020;
  localparam [8:0] S_GRANT  = 9'h040;
  localparam [8:0] S_EGRANT = 9'h080;
  localparam [8:0] S_GSNP   = 9'h100;
  // Operating point sub-sequence
  localparam [3:0] P_STEADY  = 4'h1;
  localparam [3:0] P_RATIO   = 4'h2;
  localparam [3:0] P_VIDWAIT = 4'h4;
  localparam [3:0] P_SETTLE  = 4'h8;

  function [5:0] maxVid;
    input [5:0] a;
    input [5:0] b;
    begin
      maxVid = (a > b) ? a : b;
    end
  endfunction

  function [4:0] capRatio;
    input [4:0] r;
    begin
      capRatio = (r > `LPSC_RATIO_TOP) ? `LPSC_RATIO_TOP : r;
    end
  endfunction

  // Two-stage synchronisers for chipset pins
  reg [4:0] pinMeta_reg;
  reg [4:0] pinSync_reg;
  always @(posedge ref_clk) begin
    if (rst) begin
      pinMeta_reg <= 5'h0e; // Idle levels, so no false break after reset
      pinSync_reg <= 5'h0e;
    end else begin
      pinMeta_reg <= {local_irq_pins[1], init_request_n, system_mgmt_irq_n,
                      stop_clock_request_n, local_irq_pins[0]};
      pinSync_reg <= pinMeta_reg;
    end
  end
  wire stopReq   = ~pinSync_reg[1];
  wire mgmtIrq   = ~pinSync_reg[2];
  wire initReq   = ~pinSync_reg[3];
  wire [1:0] lint = {pinSync_reg[4], pinSync_reg[0]};
  wire [3:0] breakVec = {lint, initReq, mgmtIrq};
  wire anyBreak = |breakVec;

  reg [8:0] state_reg;
  reg [8:0] state_next;
  reg [7:0] grantCnt_reg;
  reg       enhGrant_reg;
  reg       fromHalt_reg;
  reg       snpEnh_reg;
  reg       smiHalt_reg;
  reg [3:0] op_reg;
  reg [7:0] settle_reg;
  reg       lowPoint_reg;
  reg [4:0] ratioTarget;
  reg [5:0] vidTarget;
  wire      vidSettled;
  wire [3:0] pending;

  assign powerState = state_reg;
  assign coreClockStopped = ~state_reg[0] & ~state_reg[5];

  wire inGrant = state_reg[6] | state_reg[7] | state_reg[8];

  // Events are held while stop-grant is active, released on normal
  lpsc_event_latch #(
    .WIDTH (4)
  ) uLatch (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .eventIn    (breakVec),
    .holdOff    (inGrant),
    .releaseAll (state_reg == S_NORMAL),
    .pendingOut (pending)
  );

  lpsc_vid_stepper #(
    .STEP_CYC (STEP_CYC)
  ) uVid (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .targetCode (vidTarget),
    .vidCode    (voltage_id_code),
    .vidSettled (vidSettled)
  );

  // Wanted operating point: low point in enhanced states, else perf
  wire wantLow = state_reg[2] | state_reg[4] | state_reg[7]
               | (state_reg[8] & snpEnh_reg);
  wire [4:0] perfRatio = capRatio((perfRatio0 > perfRatio1) ?
                                  perfRatio0 : perfRatio1);
  wire [5:0] perfVid = maxVid(perfVid0, perfVid1);

  // Ratio and voltage ordering; core clock only, bus clock untouched
  always @(posedge ref_clk) begin
    if (rst) begin
      op_reg       <= P_STEADY;
      coreRatio    <= `LPSC_RATIO_RESET;
      ratioTarget  <= `LPSC_RATIO_RESET;
      vidTarget    <= `LPSC_VID_RESET;
      settle_reg   <= 8'h00;
      lowPoint_reg <= 1'b0;
    end else begin
      case (op_reg)
        P_STEADY: begin
          if (wantLow && !lowPoint_reg) begin
            ratioTarget  <= lowRatio;
            lowPoint_reg <= 1'b1;
            op_reg       <= P_RATIO;
          end else if (!wantLow && lowPoint_reg) begin
            vidTarget    <= perfVid;
            ratioTarget  <= perfRatio;
            lowPoint_reg <= 1'b0;
            op_reg       <= P_VIDWAIT;
          end else if (!wantLow && perfRatio > coreRatio) begin
            vidTarget   <= perfVid;
            ratioTarget <= perfRatio;
            op_reg      <= P_VIDWAIT;
          end else if (!wantLow && perfRatio < coreRatio) begin
            ratioTarget <= perfRatio;
            op_reg      <= P_RATIO;
          end else if (!wantLow) begin
            vidTarget <= perfVid;
          end
        end
        P_RATIO: begin
          coreRatio  <= ratioTarget;
          settle_reg <= SETTLE_CYC;
          op_reg     <= P_SETTLE;
        end
        P_SETTLE: begin
          if (settle_reg != 8'h00) begin
            settle_reg <= settle_reg - 8'h01;
          end else begin
            vidTarget <= lowPoint_reg ? lowVid : perfVid;
            op_reg    <= P_STEADY;
          end
        end
        P_VIDWAIT: begin
          if (vidSettled && voltage_id_code == vidTarget) begin
            op_reg <= P_RATIO;
          end
        end
        default: op_reg <= P_STEADY;
      endcase
    end
  end

  // Next power state
  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_NORMAL: begin
        if (stopReq) begin
          state_next = S_GWAIT;
        end else if (smiHalt_reg) begin
          if (handlerDone && resumeHalt && &coreHalted && !anyBreak) begin
            state_next = enhHaltEnable ? S_EHALT : S_HALT;
          end
        end else if (&coreHalted && !anyBreak) begin
          state_next = enhHaltEnable ? S_EHALT : S_HALT;
        end
      end
      S_HALT, S_EHALT: begin
        if (anyBreak) begin
          state_next = S_NORMAL;
        end else if (stopReq) begin
          state_next = S_GWAIT;
        end else if (snoopSeen) begin
          state_next = state_reg[2] ? S_EHSNP : S_HSNP;
        end
      end
      S_HSNP: begin
        if (snoopServiced) begin
          state_next = S_HALT;
        end
      end
      S_EHSNP: begin
        if (snoopServiced) begin
          state_next = S_EHALT;
        end
      end
      S_GWAIT: begin
        if (!stopReq) begin
          state_next = fromHalt_reg ? S_HALT : S_NORMAL;
        end else if (grantCnt_reg == 8'h01) begin
          state_next = enhGrant_reg ? S_EGRANT : S_GRANT;
        end
      end
      S_GRANT, S_EGRANT: begin
        if (!stopReq) begin
          state_next = fromHalt_reg ? S_HALT : S_NORMAL;
        end else if (snoopSeen) begin
          state_next = S_GSNP;
        end
      end
      S_GSNP: begin
        if (snoopServiced) begin
          state_next = snpEnh_reg ? S_EGRANT : S_GRANT;
        end
      end
      default: state_next = S_NORMAL;
    endcase
  end

  // Single state register, one transition per clock
  always @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= S_NORMAL;
    end else begin
      state_reg <= state_next;
    end
  end

  // Acknowledge cycle; the response edge is the first grant delay cycle
  always @(posedge ref_clk) begin
    if (rst) begin
      ackCycleReq  <= 1'b0;
      grantCnt_reg <= 8'h00;
      enhGrant_reg <= 1'b0;
      fromHalt_reg <= 1'b0;
      snpEnh_reg   <= 1'b0;
      smiHalt_reg  <= 1'b0;
    end else begin
      if (state_reg != S_GWAIT && state_next == S_GWAIT) begin
        ackCycleReq  <= 1'b1;
        grantCnt_reg <= 8'h00;
        enhGrant_reg <= enhGrantEnable;
        fromHalt_reg <= ~state_reg[0];
      end else if (ackCycleReq && ackResponse) begin
        ackCycleReq  <= 1'b0;
        grantCnt_reg <= GRANT_DELAY - 8'h01;
      end else if (state_reg == S_GWAIT && grantCnt_reg > 8'h01) begin
        grantCnt_reg <= grantCnt_reg - 8'h01;
      end else if (state_reg != S_GWAIT) begin
        ackCycleReq <= 1'b0;
      end
      if (state_reg == S_GRANT || state_reg == S_EGRANT) begin
        snpEnh_reg <= state_reg[7];
      end
      if (state_reg[1] | state_reg[2]) begin
        smiHalt_reg <= mgmtIrq;
      end else if (handlerDone) begin
        smiHalt_reg <= 1'b0;
      end
    end
  end

  // Initialization and break servicing
  always @(posedge ref_clk) begin
    if (rst) begin
      initStart     <= 1'b0;
      serviceEvents <= 4'h0;
    end else begin
      initStart <= initReq && (state_reg[1] | state_reg[2]
                 | inGrant);
      if (state_reg == S_NORMAL) begin
        serviceEvents <= pending | breakVec;
      end else if (state_reg[1] | state_reg[2]) begin
        serviceEvents <= breakVec;
      end else begin
        serviceEvents <= 4'h0;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/lpsc_controller_props.sv
`timescale 1ns/1ps
`default_nettype none
// Checks state order and operating-point sequencing at the ports
module lpsc_controller_props (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst,
  // Requests and configuration
  input wire logic [1:0] coreHalted,
  input wire logic       stop_clock_request_n,
  input wire logic       ackResponse,
  input wire logic       snoopServiced,
  input wire logic [4:0] lowRatio,
  input wire logic [5:0] perfVid0,
  input wire logic [5:0] perfVid1,
  // Design outputs
  input wire logic       ackCycleReq,
  input wire logic [8:0] powerState,
  input wire logic [3:0] serviceEvents,
  input wire logic [4:0] coreRatio,
  input wire logic [5:0] voltage_id_code
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // State register and entry conditions
  state_onehot_a: assert property ($onehot(powerState))
    else $error("state not one-hot");
  halt_entry_a: assert property (powerState == 9'h001 ##1
    (powerState[1] | powerState[2]) |->
    (&$past(coreHalted) || &$past(coreHalted, 2)))
    else $error("halt entered with a core running");
  // Grant timing; the pin is synced, so release takes a few cycles
  grant_delay_a: assert property (ackResponse |->
    ##19 powerState == 9'h020 ##1 (powerState[6] | powerState[7]))
    else $error("grant not 20 cycles after response");
  ack_issue_a: assert property (powerState != 9'h020 ##1
    powerState == 9'h020 |-> ackCycleReq)
    else $error("no acknowledge cycle on grant request");
  grant_hold_a: assert property (powerState == 9'h040 &&
    !stop_clock_request_n |=> powerState[6] | powerState[8])
    else $error("grant left while stop held");
  grant_release_a: assert property (powerState == 9'h040 &&
    stop_clock_request_n |-> ##[1:5] (powerState[0] | powerState[1]))
    else $error("grant not left on release");
  grant_quiet_a: assert property (powerState[8:6] != 3'h0 |->
    serviceEvents == 4'h0)
    else $error("event serviced during grant");
  // Snoop states return to where they came from
  halt_snoop_a: assert property (powerState == 9'h008 &&
    snoopServiced |-> ##[1:2] powerState == 9'h002)
    else $error("halt snoop did not return");
  ehalt_snoop_a: assert property (powerState == 9'h010 &&
    snoopServiced |-> coreRatio == lowRatio ##[1:2] powerState == 9'h004)
    else $error("enhanced snoop lost its operating point");
  // Voltage falls only with the ratio stable, and at lowRatio outside normal
  vid_order_a: assert property (
    voltage_id_code < $past(voltage_id_code) |-> $stable(coreRatio) &&
    (powerState[0] || coreRatio == lowRatio))
    else $error("voltage lowered before ratio");
  ratio_raise_a: assert property (
    coreRatio > $past(coreRatio) |-> voltage_id_code >=
    (perfVid0 > perfVid1 ? perfVid0 : perfVid1))
    else $error("ratio raised before voltage");
endmodule
`default_nettype wire

// File: tb/lpsc_chipset_model.sv
`timescale 1ns/1ps
`default_nettype none
// Chipset side: answers the acknowledge cycle and runs snoops
module lpsc_chipset_model (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Requests and answer delay
  input  wire logic       ackCycleReq,
  input  wire logic       snoopGo,
  input  wire logic [3:0] respWait,
  // Bus cycle status
  output var  logic       ackResponse,
  output var  logic       snoopSeen,
  output var  logic       snoopServiced
);
  logic [3:0] ackCnt;
  logic [3:0] snpCnt;
  logic       ackDone;
  logic       snpBusy;
  // Pulses drop back so inputs rest inactive during grant
  always @(posedge ref_clk) begin
    ackResponse <= 1'b0;
    snoopSeen <= 1'b0;
    snoopServiced <= 1'b0;
    // One response per request; done stops a repeat while req lingers
    if (rst | !ackCycleReq) begin
      ackCnt <= 4'h0;
      ackDone <= 1'b0;
    end else if (!ackDone) begin
      ackCnt <= ackCnt + 4'h1;
      if (ackCnt == respWait) begin
        ackResponse <= 1'b1;
        ackDone <= 1'b1;
      end
    end
    // Snoop seen, then serviced by some agent after the wait
    if (rst) begin
      snpBusy <= 1'b0;
      snpCnt <= 4'h0;
    end else if (snoopGo & !snpBusy) begin
      snoopSeen <= 1'b1;
      snpBusy <= 1'b1;
      snpCnt <= 4'h0;
    end else if (snpBusy) begin
      snpCnt <= snpCnt + 4'h1;
      if (snpCnt == respWait) begin
        snoopServiced <= 1'b1;
        snpBusy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/lpsc_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "lpsc_regs.vh"
module lpsc_controller_tb;
  localparam [5:0] VN  = `LPSC_VID_RESET;
  localparam [4:0] RN  = `LPSC_RATIO_RESET;
  localparam [5:0] VLO = 6'h10;
  localparam [4:0] RLO = 5'h06;
  logic       ref_clk, rst, handlerDone, resumeHalt, stopN, snoopGo;
  logic       enhHaltEnable, enhGrantEnable, ackResponse, snoopSeen;
  logic       snoopServiced, ackCycleReq, initStart, coreClockStopped;
  logic       initSeen;
  logic [1:0] coreHalted;
  logic [3:0] evt, respWait, serviceEvents;
  logic [4:0] lowRatio, perfRatio0, perfRatio1, coreRatio;
  logic [5:0] lowVid, perfVid0, perfVid1, voltage_id_code;
  logic [8:0] powerState;
  int         n_mismatch = 0;
  int         comparisons = 0;
  int         cycles = 0;
  lpsc_controller u_lpsc_controller (
    .ref_clk, .rst, .coreHalted, .handlerDone, .resumeHalt,
    .stop_clock_request_n(stopN), .system_mgmt_irq_n(!evt[0]),
    .init_request_n(!evt[1]), .local_irq_pins(evt[3:2]),
    .ackResponse, .snoopSeen, .snoopServiced, .enhHaltEnable,
    .enhGrantEnable, .lowRatio, .lowVid, .perfRatio0, .perfRatio1,
    .perfVid0, .perfVid1, .powerState, .ackCycleReq, .initStart,
    .serviceEvents, .coreRatio, .voltage_id_code, .coreClockStopped
  );
  lpsc_chipset_model u_lpsc_chipset_model (
    .ref_clk, .rst, .ackCycleReq, .snoopGo, .respWait, .ackResponse,
    .snoopSeen, .snoopServiced
  );
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Hang guard and init capture; init may be a one-cycle pulse
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (initStart === 1'b1)
      initSeen <= 1'b1;
    if (cycles == 20000) begin
      n_mismatch++;
      close_out();
    end
  end
  task tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bounded wait for a state and operating point, then compare
  task settle(input logic [8:0] s, input logic [5:0] v, input logic [4:0] r);
    for (int i = 0; i < 600 && !(powerState === s &&
         voltage_id_code === v && coreRatio === r); i++)
      tick(1);
    check(powerState, s);
    check(voltage_id_code, v);
    check(coreRatio, r);
  endtask
  task snoop(input logic [8:0] sn, input logic [8:0] back,
             input logic [5:0] v, input logic [4:0] r);
    snoopGo = 1'b1;
    tick(1);
    snoopGo = 1'b0;
    settle(sn, v, r);
    settle(back, v, r);
  endtask
  // Held three cycles so the pin synchronizer sees it
  task pulse(input int i);
    evt = 4'h1 << i;
    tick(3);
    evt = 4'h0;
    tick(2);
  endtask
  task t_halt;
    coreHalted = 2'b01;
    tick(10);
    check(powerState, 9'h001);
    check(coreClockStopped, 1'b0);
    coreHalted = 2'b11;
    settle(9'h002, VN, RN);
    check(coreClockStopped, 1'b1);
    snoop(9'h008, 9'h002, VN, RN);
    stopN = 1'b0;
    settle(9'h040, VN, RN);
    initSeen = 1'b0;
    pulse(1);
    check(initSeen, 1'b1);
    check(powerState, 9'h040);
    stopN = 1'b1;
    settle(9'h002, VN, RN);
    for (int i = 0; i < 4; i++) begin
      coreHalted = 2'b11;
      settle(9'h002, VN, RN);
      coreHalted = 2'b00;
      initSeen = 1'b0;
      pulse(i);
      settle(9'h001, VN, RN);
      handlerDone = 1'b1;
      tick(1);
      handlerDone = 1'b0;
      if (i == 1)
        check(initSeen, 1'b1);
    end
    // Handler return after a management interrupt from halt resumes halt
    coreHalted = 2'b11;
    settle(9'h002, VN, RN);
    pulse(0);
    settle(9'h001, VN, RN);
    tick(4);
    check(powerState, 9'h001);
    handlerDone = 1'b1;
    resumeHalt = 1'b1;
    tick(1);
    handlerDone = 1'b0;
    resumeHalt = 1'b0;
    settle(9'h002, VN, RN);
    coreHalted = 2'b00;
    pulse(2);
    settle(9'h001, VN, RN);
    $display("halt test done");
  endtask
  // Events pulsed twice in grant must come out once each
  task t_grant;
    logic [15:0] rises;
    logic [3:0]  prevEv, seenEv;
    respWait = 4'h5;
    stopN = 1'b0;
    settle(9'h040, VN, RN);
    repeat (2) begin
      pulse(0);
      pulse(2);
    end
    snoop(9'h100, 9'h040, VN, RN);
    stopN = 1'b1;
    rises = 16'h0;
    seenEv = 4'h0;
    prevEv = 4'h0;
    repeat (40) begin
      tick(1);
      rises += 16'($countones(serviceEvents & ~prevEv));
      seenEv |= serviceEvents;
      prevEv = serviceEvents;
    end
    check(powerState, 9'h001);
    check(seenEv, 4'h5);
    check(rises, 16'h2);
    $display("grant test done");
  endtask
  task t_enh;
    enhHaltEnable = 1'b1;
    enhGrantEnable = 1'b1;
    coreHalted = 2'b11;
    settle(9'h004, VLO, RLO);
    snoop(9'h010, 9'h004, VLO, RLO);
    coreHalted = 2'b00;
    pulse(3);
    settle(9'h001, VN, RN);
    respWait = 4'h0;
    stopN = 1'b0;
    settle(9'h080, VLO, RLO);
    stopN = 1'b1;
    settle(9'h001, VN, RN);
    $display("enhanced test done");
  endtask
  // Lower first, then raise past the top ratio
  task t_perf;
    perfRatio0 = 5'h08;
    perfRatio1 = 5'h08;
    perfVid0 = 6'h1c;
    perfVid1 = 6'h1c;
    settle(9'h001, 6'h1c, 5'h08);
    perfVid1 = 6'h22;
    perfRatio1 = 5'h1f;
    settle(9'h001, 6'h22, `LPSC_RATIO_TOP);
    $display("performance test done");
  endtask
  task close_out;
    $display("counts: %0d compared, %0d mismatched", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    rst = 1'b1;
    initSeen = 1'b0;
    coreHalted = 2'b00;
    handlerDone = 1'b0;
    resumeHalt = 1'b0;
    stopN = 1'b1;
    snoopGo = 1'b0;
    evt = 4'h0;
    respWait = 4'h2;
    enhHaltEnable = 1'b0;
    enhGrantEnable = 1'b0;
    lowRatio = RLO;
    lowVid = VLO;
    perfRatio0 = RN;
    perfRatio1 = RN;
    perfVid0 = VN;
    perfVid1 = VN;
    tick(16);
    rst = 1'b0;
    tick(3);
    settle(9'h001, VN, RN);
    check(serviceEvents, 4'h0);
    t_halt();
    t_grant();
    t_enh();
    t_perf();
    close_out();
  end
endmodule
bind lpsc_controller lpsc_controller_props u_lpsc_controller_props (
  .ref_clk, .rst, .coreHalted, .stop_clock_request_n, .ackResponse,
  .snoopServiced, .lowRatio, .perfVid0, .perfVid1, .ackCycleReq, .powerState,
  .serviceEvents, .coreRatio, .voltage_id_code
);
`default_nettype wire
